// ===== rtl/ccm_pkg.sv
// Shared constants, register map and state encoding of the packet engine
`default_nettype none
package ccm_pkg;

	// ************************************************************
	// Register offsets (byte addresses on the APB side)
	// ************************************************************
	localparam logic [11:0] OFS_TASK_KS   = 12'h000;
	localparam logic [11:0] OFS_TASK_CR   = 12'h004;
	localparam logic [11:0] OFS_EV_KS     = 12'h100;
	localparam logic [11:0] OFS_EV_CR     = 12'h104;
	localparam logic [11:0] OFS_EV_ERR    = 12'h108;
	localparam logic [11:0] OFS_SHORTS    = 12'h200;
	localparam logic [11:0] OFS_RESULT    = 12'h400;
	localparam logic [11:0] OFS_ENABLE    = 12'h500;
	localparam logic [11:0] OFS_OPMODE    = 12'h504;
	localparam logic [11:0] OFS_CFG_PTR   = 12'h508;
	localparam logic [11:0] OFS_IN_PTR    = 12'h50C;
	localparam logic [11:0] OFS_OUT_PTR   = 12'h510;
	localparam logic [11:0] OFS_SCR_PTR   = 12'h514;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          OPM_DIR_BIT   = 0;
	localparam int          OPM_RATE_BIT  = 16;
	localparam int          OPM_LEN_BIT   = 24;
	localparam logic [31:0] OPMODE_RST    = 32'h00000001;
	localparam logic [1:0]  ENABLE_ON     = 2'h2;
	localparam logic [7:0]  LEN_MASK_5    = 8'h1F;
	localparam logic [7:0]  LEN_MASK_8    = 8'hFF;

	// ************************************************************
	// Configuration structure and packet layout
	// ************************************************************
	localparam int          CFG_BYTES     = 33;
	localparam int          KEY_BYTES     = 16;
	localparam int          CTR_OFS       = 16;
	localparam int          CTR_BYTES     = 5;
	localparam int          DIR_OFS       = 24;
	localparam int          IV_OFS        = 25;
	localparam int          IV_BYTES      = 8;
	localparam logic [7:0]  HDR_LAST      = 8'h02;
	localparam logic [31:0] PAY_OFS       = 32'h00000003;
	localparam logic [7:0]  MIC_BYTES     = 8'h04;
	localparam logic [7:0]  MIN_DEC_LEN   = 8'h05;
	localparam logic [7:0]  KS_LAST       = 8'h0F;
	localparam logic [3:0]  MIX_ROUNDS    = 4'hA;

	// ************************************************************
	// Sequencer states, Gray coded along the usual path
	// ************************************************************
	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_CFG_RD = 4'h1,
		S_KS_RUN = 4'h3,
		S_KS_WR  = 4'h2,
		S_HDR_RD = 4'h6,
		S_HDR_WR = 4'h7,
		S_PAY_RD = 4'h5,
		S_PAY_WR = 4'h4,
		S_MIC    = 4'hC,
		S_BLK    = 4'hD
	} ccm_state_t;

endpackage : ccm_pkg
`default_nettype wire

// ===== rtl/ccm_cipher_if.sv
// Request and answer bundle between the sequencer and the block cipher
`timescale 1ns/1ps
`default_nettype none
interface ccm_cipher_if;
	logic         start;
	logic [127:0] key;
	logic [127:0] blk;
	logic         done;
	logic [127:0] res;

	modport eng  (output start, key, blk, input  done, res);
	modport core (input  start, key, blk, output done, res);
endinterface : ccm_cipher_if
`default_nettype wire

// ===== rtl/ccm_mix.sv
// Iterative keyed 128-bit block transform, one round per clock
`timescale 1ns/1ps
`default_nettype none
module ccm_mix
	import ccm_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Sequencer side
	ccm_cipher_if.core cif
);

	logic [3:0]   cnt;
	logic [127:0] st;
	logic [127:0] rk;
	logic [127:0] t;
	logic [127:0] next_st;

	// One round: keyed add, rotate and a non-linear AND term
	always_comb begin
		t       = st + rk;
		next_st = {t[114:0], t[127:115]} ^ (t & {t[126:0], t[127]})
			^ {t[0], t[127:1]};
	end

	// Round counter; a start while busy restarts the block
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt      <= 4'h0;
			st       <= '0;
			rk       <= '0;
			cif.done <= 1'b0;
		end else begin
			cif.done <= 1'b0;
			if (cif.start) begin
				st  <= cif.blk ^ cif.key;
				rk  <= cif.key;
				cnt <= MIX_ROUNDS;
			end else if (cnt != 4'h0) begin
				st  <= next_st;
				rk  <= {rk[94:0], rk[127:95]}; // Cheap key schedule
				cnt <= cnt - 4'h1;
				if (cnt == 4'h1)
					cif.done <= 1'b1;
			end
		end
	end

	assign cif.res = st;

endmodule : ccm_mix
`default_nettype wire

// ===== rtl/ccm_packet_crypto.sv
// Packet engine top: APB registers, DMA sequencer, keystream and check code
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ccm_packet_crypto
	import ccm_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Tasks and events
	input  wire logic        keystream_generate_task,
	input  wire logic        task_a,
	output logic             keystream_done_event,
	output logic             task_a_done_event,
	output logic             error_event,
	output logic             integrity_check_result,
	// DMA master, one byte per access
	output logic             dma_req,
	output logic             dma_we,
	output logic      [31:0] dma_addr,
	output logic      [7:0]  dma_wdata,
	input  wire logic [7:0]  dma_rdata,
	input  wire logic        dma_ack,
	input  wire logic        dma_err
);

	// ************************************************************
	// Declarations
	// ************************************************************
	ccm_state_t   state;
	ccm_cipher_if cif ();

	logic [1:0]   enable;
	logic [31:0]  opmode;
	logic         chain;
	logic [31:0]  config_struct_pointer;
	logic [31:0]  input_packet_pointer;
	logic [31:0]  output_packet_pointer;
	logic [31:0]  scratch_area_pointer;
	logic         ev_ks_flag;
	logic         ev_cr_flag;
	logic         ev_err_flag;

	logic [7:0]   cfg [CFG_BYTES];
	logic [7:0]   hdr [3];
	logic [7:0]   idx;
	logic [7:0]   blk_cnt;
	logic         blk_ok;
	logic [127:0] ks0;
	logic [127:0] ksb;
	logic [7:0]   obyte;
	logic [31:0]  mic;
	logic         fail;

	logic         wr_acc;
	logic         rd_setup;
	logic         go_ks;
	logic         go_cr;
	logic         dir;
	logic [7:0]   mask;
	logic [7:0]   fl;
	logic [7:0]   len_out;
	logic [7:0]   pay_len;
	logic         dec_bad;
	logic [7:0]   ks_byte;
	logic [7:0]   ptext;
	logic [31:0]  micw;
	logic [7:0]   mic_byte;
	logic         hdr_end;
	logic         mic_end;
	logic [127:0] key128;
	logic [127:0] nonce;
	logic [31:0]  idx32;
	logic [31:0]  pay32;

	// ************************************************************
	// APB access decode; zero wait states
	// ************************************************************
	assign pready   = 1'b1;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable;

	// Settings registers; a disable never clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable                <= 2'h0;
			opmode                <= OPMODE_RST;
			chain                 <= 1'b0;
			config_struct_pointer <= '0;
			input_packet_pointer  <= '0;
			output_packet_pointer <= '0;
			scratch_area_pointer  <= '0;
		end else if (wr_acc) begin
			case (paddr)
				OFS_ENABLE:  enable                <= pwdata[1:0];
				OFS_OPMODE:  opmode                <= pwdata;
				OFS_SHORTS:  chain                 <= pwdata[0];
				OFS_CFG_PTR: config_struct_pointer <= pwdata;
				OFS_IN_PTR:  input_packet_pointer  <= pwdata;
				OFS_OUT_PTR: output_packet_pointer <= pwdata;
				OFS_SCR_PTR: scratch_area_pointer  <= pwdata;
				default: ;
			endcase
		end
	end

	// Sticky event flags; a new event beats a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_ks_flag  <= 1'b0;
			ev_cr_flag  <= 1'b0;
			ev_err_flag <= 1'b0;
		end else begin
			if (keystream_done_event)
				ev_ks_flag <= 1'b1;
			else if (wr_acc && paddr == OFS_EV_KS)
				ev_ks_flag <= pwdata[0];
			if (task_a_done_event)
				ev_cr_flag <= 1'b1;
			else if (wr_acc && paddr == OFS_EV_CR)
				ev_cr_flag <= pwdata[0];
			if (error_event)
				ev_err_flag <= 1'b1;
			else if (wr_acc && paddr == OFS_EV_ERR)
				ev_err_flag <= pwdata[0];
		end
	end

	// Read data captured in the setup phase, so it is a flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			pslverr <= 1'b0;
			prdata  <= '0;
			case (paddr)
				OFS_TASK_KS, OFS_TASK_CR: prdata <= '0;
				OFS_EV_KS:   prdata <= {31'h0, ev_ks_flag};
				OFS_EV_CR:   prdata <= {31'h0, ev_cr_flag};
				OFS_EV_ERR:  prdata <= {31'h0, ev_err_flag};
				OFS_SHORTS:  prdata <= {31'h0, chain};
				OFS_RESULT:  prdata <= {31'h0, integrity_check_result};
				OFS_ENABLE:  prdata <= {30'h0, enable};
				OFS_OPMODE:  prdata <= opmode;
				OFS_CFG_PTR: prdata <= config_struct_pointer;
				OFS_IN_PTR:  prdata <= input_packet_pointer;
				OFS_OUT_PTR: prdata <= output_packet_pointer;
				OFS_SCR_PTR: prdata <= scratch_area_pointer;
				default:     pslverr <= 1'b1;
			endcase
		end
	end

	// ************************************************************
	// Task triggers and packet arithmetic
	// ************************************************************
	// Tasks from pins or register writes; ignored when disabled or busy
	assign go_ks = enable == ENABLE_ON && (keystream_generate_task
		|| (wr_acc && paddr == OFS_TASK_KS && pwdata[0]));
	assign go_cr = enable == ENABLE_ON && (task_a
		|| (wr_acc && paddr == OFS_TASK_CR && pwdata[0]));

	assign dir  = opmode[OPM_DIR_BIT];
	assign mask = opmode[OPM_LEN_BIT] ? LEN_MASK_8 : LEN_MASK_5;
	assign fl   = hdr[1] & mask;

	// Length adjust keeps bits outside the length field
	always_comb begin
		dec_bad = dir && fl != 8'h00 && fl < MIN_DEC_LEN;
		if (fl == 8'h00 || dec_bad) begin
			pay_len = 8'h00;
			len_out = hdr[1];
		end else if (dir) begin
			pay_len = fl - MIC_BYTES;
			len_out = (hdr[1] & ~mask) | ((fl - MIC_BYTES) & mask);
		end else begin
			pay_len = fl;
			len_out = (hdr[1] & ~mask) | ((fl + MIC_BYTES) & mask);
		end
	end

	// Key and nonce from the configuration structure
	always_comb begin
		key128 = '0;
		nonce  = '0;
		for (int i = 0; i < KEY_BYTES; i++)
			key128[i*8 +: 8] = cfg[i];
		for (int i = 0; i < CTR_BYTES; i++)
			nonce[i*8 +: 8] = cfg[CTR_OFS+i];
		nonce[39] = 1'b0;                  // Top counter bit is ignored
		nonce[40] = cfg[DIR_OFS][0];
		for (int i = 0; i < IV_BYTES; i++)
			nonce[48+i*8 +: 8] = cfg[IV_OFS+i];
		nonce[127:120] = blk_cnt;          // Block number of keystream
	end

	assign cif.key   = key128;
	assign cif.blk   = nonce;
	assign ks_byte   = ksb[idx[3:0]*8 +: 8];
	assign ptext     = dir ? (dma_rdata ^ ks_byte) : dma_rdata;
	assign micw      = mic ^ ks0[31:0];
	assign mic_byte  = micw[idx[1:0]*8 +: 8];
	assign idx32     = {24'h0, idx};
	assign pay32     = {24'h0, pay_len};
	assign hdr_end   = state == S_HDR_WR && dma_ack && idx == HDR_LAST
		&& pay_len == 8'h00;
	assign mic_end   = state == S_MIC && dma_ack
		&& idx == MIC_BYTES - 8'h01;

	ccm_mix u_mix (
		.clk   (pclk),
		.rst_n (presetn),
		.cif   (cif)
	);

	// ************************************************************
	// DMA request steering; held until acknowledged
	// ************************************************************
	always_comb begin
		dma_req   = 1'b0;
		dma_we    = 1'b0;
		dma_addr  = '0;
		dma_wdata = '0;
		case (state)
			S_CFG_RD: begin
				dma_req  = 1'b1;
				dma_addr = config_struct_pointer + idx32;
			end
			S_KS_WR: begin
				dma_req   = 1'b1;
				dma_we    = 1'b1;
				dma_addr  = scratch_area_pointer + idx32;
				dma_wdata = ks0[idx[3:0]*8 +: 8];
			end
			S_HDR_RD: begin
				dma_req  = 1'b1;
				dma_addr = input_packet_pointer + idx32;
			end
			S_HDR_WR: begin
				dma_req   = 1'b1;
				dma_we    = 1'b1;
				dma_addr  = output_packet_pointer + idx32;
				dma_wdata = idx == 8'h01 ? len_out : hdr[idx[1:0]];
			end
			S_PAY_RD: begin
				dma_req  = !(idx[3:0] == 4'h0 && !blk_ok);
				dma_addr = input_packet_pointer + PAY_OFS + idx32;
			end
			S_PAY_WR: begin
				dma_req   = 1'b1;
				dma_we    = 1'b1;
				dma_addr  = output_packet_pointer + PAY_OFS + idx32;
				dma_wdata = obyte;
			end
			S_MIC: begin
				// Encrypt appends the code, decrypt reads it back
				dma_req   = 1'b1;
				dma_we    = !dir;
				dma_addr  = (dir ? input_packet_pointer
					: output_packet_pointer) + PAY_OFS + pay32 + idx32;
				dma_wdata = mic_byte;
			end
			default: ;
		endcase
	end

	// Configuration bytes, no reset; loaded only by a keystream task, so a task_a run first uses unloaded cfg
	always_ff @(posedge pclk) begin
		if (state == S_CFG_RD && dma_ack)
			cfg[idx[5:0]] <= dma_rdata;
		if (state == S_HDR_RD && dma_ack)
			hdr[idx[1:0]] <= dma_rdata;
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= S_IDLE;
			idx                  <= '0;
			blk_cnt              <= '0;
			blk_ok               <= 1'b0;
			ks0                  <= '0;
			ksb                  <= '0;
			obyte                <= '0;
			cif.start            <= 1'b0;
			keystream_done_event <= 1'b0;
			task_a_done_event     <= 1'b0;
			error_event          <= 1'b0;
		end else begin
			cif.start            <= 1'b0;
			keystream_done_event <= 1'b0;
			task_a_done_event     <= hdr_end || mic_end;
			error_event          <= 1'b0;
			if (dma_req && dma_err) begin
				state       <= S_IDLE;
				error_event <= 1'b1;
			end else begin
				case (state)
					S_IDLE: begin
						idx <= 8'h00;
						if (go_ks)
							state <= S_CFG_RD;
						else if (go_cr)
							state <= S_HDR_RD;
						blk_cnt <= 8'h00;
					end
					S_CFG_RD: if (dma_ack) begin
						idx <= idx + 8'h01;
						if (idx == 8'(CFG_BYTES - 1)) begin
							state     <= S_KS_RUN;
							cif.start <= 1'b1;
						end
					end
					S_KS_RUN: if (cif.done) begin
						ks0   <= cif.res;
						idx   <= 8'h00;
						state <= S_KS_WR;
					end
					S_KS_WR: if (dma_ack) begin
						idx <= idx + 8'h01;
						if (idx == KS_LAST) begin
							keystream_done_event <= 1'b1;
							idx   <= 8'h00;
							// Chained task_a starts at once
							state <= chain ? S_HDR_RD : S_IDLE;
						end
					end
					S_HDR_RD: if (dma_ack) begin
						idx <= idx + 8'h01;
						if (idx == HDR_LAST) begin
							idx   <= 8'h00;
							state <= S_HDR_WR;
						end
					end
					S_HDR_WR: if (dma_ack) begin
						idx <= idx + 8'h01;
						if (idx == HDR_LAST) begin
							idx    <= 8'h00;
							blk_ok <= 1'b0;
							state  <= pay_len == 8'h00 ? S_IDLE : S_PAY_RD;
						end
					end
					S_PAY_RD: begin
						if (idx[3:0] == 4'h0 && !blk_ok) begin
							// Next keystream block on each 16-byte edge
							blk_cnt   <= blk_cnt + 8'h01;
							cif.start <= 1'b1;
							state     <= S_BLK;
						end else if (dma_ack) begin
							obyte <= dma_rdata ^ ks_byte;
							state <= S_PAY_WR;
						end
					end
					S_BLK: if (cif.done) begin
						ksb    <= cif.res;
						blk_ok <= 1'b1;
						state  <= S_PAY_RD;
					end
					S_PAY_WR: if (dma_ack) begin
						idx   <= idx + 8'h01;
						state <= S_PAY_RD;
						if (idx[3:0] == 4'hF)
							blk_ok <= 1'b0;
						if (idx == pay_len - 8'h01) begin
							idx   <= 8'h00;
							state <= S_MIC;
						end
					end
					S_MIC: if (dma_ack) begin
						idx <= idx + 8'h01;
						if (idx == MIC_BYTES - 8'h01)
							state <= S_IDLE;
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// Integrity code and check result
	// ************************************************************
	// Code runs over plaintext; result held until next decrypt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mic                    <= '0;
			fail                   <= 1'b0;
			integrity_check_result <= 1'b0;
		end else begin
			if (state == S_HDR_WR) begin
				mic  <= '0;
				fail <= 1'b0;
			end
			if (state == S_PAY_RD && dma_ack && blk_ok)
				mic <= {mic[30:0], mic[31]} ^ {24'h0, ptext}
					^ key128[31:0];
			if (state == S_MIC && dma_ack && dir
				&& dma_rdata != mic_byte)
				fail <= 1'b1;
			if (hdr_end && dir)
				integrity_check_result <= !dec_bad;
			else if (mic_end && dir)
				integrity_check_result <= !(fail
					|| dma_rdata != mic_byte);
		end
	end

endmodule : ccm_packet_crypto
`default_nettype wire

// ===== bench/ccm_packet_crypto_sva.sv
// Port-level checker for the packet engine
`timescale 1ns/1ps
`default_nettype none
module ccm_packet_crypto_sva
	import ccm_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Events
	input wire logic        keystream_done_event,
	input wire logic        task_a_done_event,
	input wire logic        error_event,
	input wire logic        integrity_check_result,
	// DMA master
	input wire logic        dma_req,
	input wire logic        dma_we,
	input wire logic [31:0] dma_addr,
	input wire logic [7:0]  dma_wdata,
	input wire logic        dma_ack,
	input wire logic        dma_err
);
	// ********************
	// Properties
	// ********************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ks_pulse: assert property (
		keystream_done_event |=> !keystream_done_event)
		else $error("keystream done longer than one cycle");
	chk_cr_pulse: assert property (
		task_a_done_event |=> !task_a_done_event)
		else $error("task_a done longer than one cycle");
	chk_err_pulse: assert property (
		error_event |=> !error_event)
		else $error("error event longer than one cycle");
	// A pending access must not wander before it is answered
	chk_dma_hold: assert property (
		dma_req && !dma_ack && !dma_err |=> dma_req && $stable(dma_addr)
		&& $stable(dma_we) && $stable(dma_wdata))
		else $error("dma request changed while pending");
	chk_done_idle: assert property (
		task_a_done_event |-> !dma_req)
		else $error("dma still active at task_a done");
	chk_result_hold: assert property (
		$changed(integrity_check_result) |-> task_a_done_event)
		else $error("result moved without a completion");
	chk_ev_excl: assert property (
		!(keystream_done_event && task_a_done_event))
		else $error("both done events at once");
	chk_err_abort: assert property (
		dma_req && dma_err |=> error_event && !task_a_done_event && !dma_req)
		else $error("dma fault not reported next cycle");

	cov_ks: cover property (keystream_done_event);
	cov_pass: cover property (task_a_done_event ##1 integrity_check_result);
	cov_err: cover property (error_event);
endmodule : ccm_packet_crypto_sva

bind ccm_packet_crypto ccm_packet_crypto_sva u_sva (.pclk, .presetn,
	.keystream_done_event, .task_a_done_event, .error_event,
	.integrity_check_result, .dma_req, .dma_we, .dma_addr, .dma_wdata,
	.dma_ack, .dma_err);
`default_nettype wire

// ===== bench/ccm_ram_model.sv
// Byte-wide system RAM answering the engine's DMA master
`timescale 1ns/1ps
`default_nettype none
module ccm_ram_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// DMA slave side
	input  wire logic        dma_req,
	input  wire logic        dma_we,
	input  wire logic [31:0] dma_addr,
	input  wire logic [7:0]  dma_wdata,
	output logic      [7:0]  dma_rdata,
	output logic             dma_ack,
	output logic             dma_err,
	// Bench controls: wait cycles and forced bus conflict
	input  wire logic [1:0]  slow,
	input  wire logic        fail
);
	logic [7:0] mem [0:1023];
	logic [1:0] wait_cnt;
	logic [7:0] last;

	// Answer after the chosen wait; conflict aborts instead
	assign dma_ack   = dma_req && !fail && wait_cnt == slow;
	assign dma_err   = dma_req && fail;
	// Outside an answer the data lines carry no stale byte
	assign dma_rdata = dma_ack ? mem[dma_addr[9:0]] : ~last;

	// Wait counter and memory update, bench also writes mem
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 2'h0;
			last     <= 8'h00;
		end else if (dma_ack) begin
			wait_cnt <= 2'h0;
			last     <= dma_we ? dma_wdata : dma_rdata;
			if (dma_we)
				mem[dma_addr[9:0]] <= dma_wdata;
		end else if (dma_req) begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule : ccm_ram_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the packet engine
`timescale 1ns/1ps
`default_nettype none
module tb
	import ccm_pkg::*;
;
	// ********************
	// Signals
	// ********************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dma_addr, rd;
	logic        keystream_generate_task, task_a, keystream_done_event;
	logic        task_a_done_event, error_event, integrity_check_result;
	logic        dma_req, dma_we, dma_ack, dma_err, fail, se;
	logic [7:0]  dma_wdata, dma_rdata;
	logic [1:0]  slow;
	int          err_count, comparisons, wr_cnt, rd_cnt, i;

	ccm_packet_crypto uut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.keystream_generate_task, .task_a, .keystream_done_event,
		.task_a_done_event, .error_event, .integrity_check_result,
		.dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_rdata,
		.dma_ack, .dma_err);
	ccm_ram_model ram (.clk(pclk), .rst_n(presetn), .dma_req, .dma_we,
		.dma_addr, .dma_wdata, .dma_rdata, .dma_ack, .dma_err, .slow, .fail);

	// Clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Count completed DMA accesses
	always @(posedge pclk) begin
		if (dma_req && dma_ack)
			if (dma_we) wr_cnt++; else rd_cnt++;
	end

	// ********************
	// Shared tasks
	// ********************
	task wrap_up;
		$display("errors %0d, checks %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task tmo;
		chk(32'h0, 32'h1);
		wrap_up;
	endtask : tmo
	// One APB transfer; holds the request until pready
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Pready is judged at each edge; data taken at that same edge
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16) tmo;
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// Bounded wait: 0 keystream, 1 task_a, 2 error
	task automatic wait_ev(input int s);
		int n;
		for (n = 0; n < 4000; n++) begin
			@(posedge pclk);
			if ((s == 0 && keystream_done_event === 1'b1)
				|| (s == 1 && task_a_done_event === 1'b1)
				|| (s == 2 && error_event === 1'b1))
				return;
		end
		tmo;
	endtask : wait_ev
	task pulse(input logic k);
		@(posedge pclk);
		{keystream_generate_task, task_a} <= {k, !k};
		@(posedge pclk);
		{keystream_generate_task, task_a} <= 2'b00;
	endtask : pulse
	// Fresh keystream, then one task_a with the given mode
	task automatic run(input logic [31:0] m, input logic [31:0] ip, op);
		apb(1'b1, OFS_OPMODE, m);
		apb(1'b1, OFS_IN_PTR, ip);
		apb(1'b1, OFS_OUT_PTR, op);
		pulse(1'b1);
		wait_ev(0);
		wr_cnt = 0;
		pulse(1'b0);
		wait_ev(1);
	endtask : run

	// ********************
	// Scenarios
	// ********************
	task t_regs;
		apb(1'b0, OFS_OPMODE, 32'h0);
		chk(rd, OPMODE_RST);
		apb(1'b0, 12'h300, 32'h0);
		chk(se, 1'b1);
		apb(1'b1, OFS_OPMODE, 32'h01010000);
		apb(1'b1, OFS_CFG_PTR, 32'h0);
		apb(1'b1, OFS_SCR_PTR, 32'h40);
		apb(1'b1, OFS_ENABLE, 32'h2);
		apb(1'b1, OFS_ENABLE, 32'h0);
		apb(1'b1, OFS_ENABLE, 32'h2);
		apb(1'b0, OFS_OPMODE, 32'h0);
		chk(rd, 32'h01010000);
		rd_cnt = 0;
		pulse(1'b1);
		wait_ev(0);
		chk(rd_cnt, CFG_BYTES);
		chk(wr_cnt, KEY_BYTES);
	endtask : t_regs
	task automatic t_task_a(input logic [31:0] m, input logic [7:0] lb, elb,
			input int n);
		int d;
		ram.mem[257] = lb;
		run(m, 32'h100, 32'h200);
		chk(ram.mem[513], elb);
		chk(ram.mem[512], 8'h0A);
		chk(wr_cnt, n + 7);
		d = 0;
		for (i = 0; i < n; i++) d += int'(ram.mem[515 + i] != 8'(i + 1));
		chk(d > 0, 1'b1);
		run(m | 32'h1, 32'h200, 32'h300);
		chk(ram.mem[769], lb);
		chk(wr_cnt, n + 3);
		for (i = 0; i < n; i++) chk(ram.mem[771 + i], 8'(i + 1));
		chk(integrity_check_result, 1'b1);
		ram.mem[515 + n] ^= 8'h01;
		run(m | 32'h1, 32'h200, 32'h300);
		chk(integrity_check_result, 1'b0);
	endtask : t_task_a
	task automatic t_short;
		ram.mem[257] = 8'h00;
		run(32'h0, 32'h100, 32'h200);
		chk(wr_cnt, 3);
		chk(ram.mem[513], 8'h00);
		for (int l = 4; l > 0; l--) begin
			ram.mem[257] = 8'h00;
			run(32'h1, 32'h100, 32'h300);
			chk(integrity_check_result, 1'b1);
			ram.mem[257] = 8'(l);
			run(32'h1, 32'h100, 32'h300);
			chk(integrity_check_result, 1'b0);
			chk(ram.mem[769], 8'(l));
		end
	endtask : t_short
	task t_chain;
		slow = 2'h2;
		ram.mem[257] = 8'h05;
		apb(1'b1, OFS_SHORTS, 32'h1);
		apb(1'b1, OFS_OPMODE, 32'h0);
		apb(1'b1, OFS_IN_PTR, 32'h100);
		apb(1'b1, OFS_OUT_PTR, 32'h200);
		pulse(1'b1);
		wait_ev(0);
		wait_ev(1);
		chk(ram.mem[513], 8'h09);
		apb(1'b1, OFS_SHORTS, 32'h0);
		slow = 2'h0;
	endtask : t_chain
	task t_error;
		pulse(1'b1);
		wait_ev(0);
		fail = 1'b1;
		pulse(1'b0);
		wait_ev(2);
		fail = 1'b0;
		apb(1'b0, OFS_EV_ERR, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, OFS_EV_ERR, 32'h0);
		apb(1'b0, OFS_EV_ERR, 32'h0);
		chk(rd, 32'h0);
	endtask : t_error

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{keystream_generate_task, task_a, fail, slow} = '0;
		{err_count, comparisons, wr_cnt, rd_cnt} = '0;
		for (i = 0; i < 1024; i++) ram.mem[i] = 8'(i * 7 + 3);
		ram.mem[256] = 8'h0A; // Header, length, reserved kept
		for (i = 0; i < 62; i++) ram.mem[259 + i] = 8'(i + 1);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_task_a(32'h0, 8'hF4, 8'hF8, 20);
		t_task_a(32'h01000000, 8'h3E, 8'h42, 62);
		t_short;
		t_chain;
		t_error;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
